// [hdl/pric_consts.svh]
`ifndef PRIC_CONSTS_SVH
`define PRIC_CONSTS_SVH

`define PRIC_NSRC         48
`define PRIC_NLVL_SRC     46
`define PRIC_NTRAP        4
`define PRIC_NFLAG_REG    3
`define PRIC_NPRIO_REG    12
`define PRIC_STK_FULL     5'h10

`define PRIC_OFF_FLAGS0   8'h00
`define PRIC_OFF_EN0      8'h0C
`define PRIC_OFF_PRIO0    8'h18
`define PRIC_OFF_GC1      8'h48
`define PRIC_OFF_GC2      8'h4C
`define PRIC_OFF_VLATCH   8'h50
`define PRIC_OFF_CPULVL   8'h54

`define PRIC_GC1_NESTING_DISABLE   15
`define PRIC_GC2_ALT      15
`define PRIC_GC2_TIMED_DISABLE     14

`define PRIC_EXT0_SRC     0
`define PRIC_EXT1_SRC     16
`define PRIC_EXT2_SRC     17
`define PRIC_ADDR_ERR     1

`define PRIC_TRAP_LVL     4'h8
`define PRIC_TRAP_VEC     7'h01
`define PRIC_INT_VEC      7'h08
`define PRIC_TIMED_DISABLE_MAX     4'h6
`define PRIC_LVL_ZERO     4'h0

`define PRIC_TBL_LO       24'h000004
`define PRIC_TBL_HI       24'h0000FE
`define PRIC_ALT_OFS      24'h000080

`endif

// [hdl/pric_pkg.sv]
package pric_pkg;
    typedef logic [3:0]  pric_lvl_t;
    typedef logic [2:0]  pric_ip_t;
    typedef logic [6:0]  pric_vec_t;
    typedef logic [5:0]  pric_src_t;
    typedef logic [23:0] pric_addr_t;
endpackage

// [hdl/pric_lvl_stack.sv]
`include "pric_consts.svh"

// Saved CPU levels of interrupted contexts; a write to the address being read is
// forwarded so the top entry is valid in the cycle right after a push.
module pric_lvl_stack (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               wr_en,
    input  wire logic [3:0]         wr_addr,
    input  wire pric_pkg::pric_lvl_t wr_data,
    input  wire logic [3:0]         rd_addr,
    output pric_pkg::pric_lvl_t     rd_data
);
    pric_pkg::pric_lvl_t mem [0:15];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data <= `PRIC_LVL_ZERO;
        end
        else
        begin
            rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
        end
    end
endmodule

// [hdl/pric_arbiter.sv]
`include "pric_consts.svh"

// Picks the enabled pending source of highest level; scanning downward lets the
// lower source number win a tie.
module pric_arbiter (
    input  wire logic [47:0]  active,
    input  wire logic [143:0] lvl_flat,
    output logic              found,
    output pric_pkg::pric_src_t win_idx,
    output pric_pkg::pric_ip_t  win_lvl
);
    always_comb
    begin
        found   = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = `PRIC_NSRC - 1; i >= 0; i--)
        begin
            if (active[i] && lvl_flat[i*3 +: 3] != 3'h0 && lvl_flat[i*3 +: 3] >= win_lvl)
            begin
                found   = 1'b1;
                win_idx = 6'(i);
                win_lvl = lvl_flat[i*3 +: 3];
            end
        end
    end
endmodule

// [hdl/pric_top.sv]
`include "pric_consts.svh"

// Contract
// - Pending flags set by sources stay set until software clears them.
// - Flags set on every event, whatever the source enable says.
// - Per-source enables gate requests; three 16-bit flag and enable registers.
// - Each source has a level 1 to 7; 7 highest, 1 lowest.
// - A source at level 0 is never presented, as if disabled.
// - Level sits in low three bits of each nibble; top bit reads zero.
// - Twelve priority registers; the last implements only its lower eight bits.
// - CPU level is four bits: bit 3 core control, bits 2-0 status.
// - Nesting disable bit 15 blocks new interrupts while one is serviced.
// - With nesting disabled, CPU level writes have no effect.
// - Timed disable blocks levels 6 and below; control-2 bit 14 reads set.
// - Latch winning vector number and level into the vector latch.
// - Equal levels pending together: lowest source number wins.
// - Natural order equals source number and only breaks ties.
// - Service loads the 24-bit vector entry; table spans 0x000004 to 0x0000FE.
// - Vector enters the program counter through a 24-bit input mux.
// - Normal fetch from vector table words raises the address error trap.
// - Control-2 selects the alternate vector table.
// - Control-2 selects the triggering edge of external requests.
// - Control-1 holds exception control and status flags and nesting disable.
// - Interrupt sources and four exceptions arbitrate under one scheme.
// - Traps take levels 8 to 11, so CPU level bit 3 is set.
// - CPU level 0111 outside a trap masks all interrupts, not traps.
module pric_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [47:0] irq_src,
    input  wire logic [2:0]  ext_req_pin,
    input  wire logic [3:0]  trap_evt,
    input  wire logic        fetch_valid,
    input  wire logic [23:0] fetch_addr,
    input  wire logic        timed_disable_start,
    input  wire logic [13:0] timed_disable_count,
    input  wire logic        instr_done,
    input  wire logic        irq_ack,
    input  wire logic        irq_ret,
    input  wire logic        vec_fetch_valid,
    input  wire logic [23:0] pdb_data,
    output logic             irq_req,
    output pric_pkg::pric_vec_t  irq_vector,
    output pric_pkg::pric_lvl_t  irq_level,
    output pric_pkg::pric_addr_t irq_vec_addr,
    output pric_pkg::pric_addr_t pc_vector,
    output logic             pc_load,
    output pric_pkg::pric_lvl_t  cpu_level
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int k);
        return a == base + 8'(k * 4);
    endfunction

    logic [47:0]         pending;
    logic [47:0]         enables;
    pric_pkg::pric_ip_t  lvl [0:47];
    logic [3:0]          trap_flags;
    logic                nesting_disable;
    logic                alt_table;
    logic [2:0]          ext_fall;
    logic [13:0]         timed_disable_cnt;
    pric_pkg::pric_vec_t latched_vector_number;
    pric_pkg::pric_lvl_t latched_request_level;
    logic [4:0]          depth;
    logic [2:0]          s1;
    logic [2:0]          s2;
    logic [2:0]          s3;
    logic [2:0]          ext_filt;

    logic [47:0]         next_pending;
    logic [47:0]         next_enables;
    logic [143:0]        lvl_flat;
    logic [31:0]         rd_word;
    logic                rd_err;
    logic                tfound;
    logic [1:0]          tidx;

    // Bus decode.
    wire apb_setup  = psel && !penable;
    wire apb_wr     = psel && penable && pwrite && pready;
    wire gc1_wr     = apb_wr && paddr == `PRIC_OFF_GC1;
    wire gc2_wr     = apb_wr && paddr == `PRIC_OFF_GC2;
    wire cpu_wr_req = apb_wr && paddr == `PRIC_OFF_CPULVL;
    wire flags_wr   = apb_wr && (hit(paddr, `PRIC_OFF_FLAGS0, 0) ||
                      hit(paddr, `PRIC_OFF_FLAGS0, 1) || hit(paddr, `PRIC_OFF_FLAGS0, 2));

    // External pins: a new level counts only once the second and third stages agree.
    wire [2:0] ext_agree = ~(s2 ^ s3);
    wire [2:0] ext_new   = (ext_agree & s3) | (~ext_agree & ext_filt);
    wire [2:0] ext_rise  = ext_new & ~ext_filt;
    wire [2:0] ext_fallq = ~ext_new & ext_filt;
    wire [2:0] ext_hit   = (ext_fall & ext_fallq) | (~ext_fall & ext_rise);
    wire [47:0] ext_set  = (48'(ext_hit[0]) << `PRIC_EXT0_SRC) |
                           (48'(ext_hit[1]) << `PRIC_EXT1_SRC) |
                           (48'(ext_hit[2]) << `PRIC_EXT2_SRC);
    wire [47:0] set_evt  = irq_src | ext_set;

    // Normal-execution fetch into vector space.
    wire in_vec_space = fetch_addr >= `PRIC_TBL_LO && fetch_addr <= `PRIC_TBL_HI;
    wire addr_err     = fetch_valid && in_vec_space;
    wire [3:0] trap_set = trap_evt | (4'(addr_err) << `PRIC_ADDR_ERR);
    wire [3:0] next_traps = (gc1_wr ? pwdata[3:0] : trap_flags) | trap_set;

    always_comb
    begin
        next_pending = pending | set_evt;
        next_enables = enables;
        for (int k = 0; k < `PRIC_NFLAG_REG; k++)
        begin
            if (apb_wr && hit(paddr, `PRIC_OFF_FLAGS0, k))
            begin
                next_pending[k*16 +: 16] = pwdata[15:0] | set_evt[k*16 +: 16];
            end
            if (apb_wr && hit(paddr, `PRIC_OFF_EN0, k))
            begin
                next_enables[k*16 +: 16] = pwdata[15:0];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < `PRIC_NSRC; i++)
        begin
            lvl_flat[i*3 +: 3] = lvl[i];
        end
    end

    // Arbitration of sources and exceptions.
    wire                 found;
    pric_pkg::pric_src_t win_idx;
    pric_pkg::pric_ip_t  win_lvl;

    pric_arbiter u_arb (
        .active   (pending & enables),
        .lvl_flat (lvl_flat),
        .found    (found),
        .win_idx  (win_idx),
        .win_lvl  (win_lvl)
    );

    always_comb
    begin
        tfound = 1'b0;
        tidx   = 2'h0;
        for (int t = 0; t < `PRIC_NTRAP; t++)
        begin
            if (trap_flags[t])
            begin
                tfound = 1'b1;
                tidx   = 2'(t);
            end
        end
    end

    wire                 take     = irq_req && irq_ack;
    wire                 pop      = irq_ret && !take && depth != 5'h00;
    wire                 push     = take && depth != `PRIC_STK_FULL;
    wire [4:0]           next_depth = push ? depth + 5'h01 : (pop ? depth - 5'h01 : depth);
    wire pric_pkg::pric_lvl_t int_lvl  = {1'b0, win_lvl};
    wire pric_pkg::pric_lvl_t trap_lvl = `PRIC_TRAP_LVL + {2'b00, tidx};
    wire nest_block = nesting_disable && depth != 5'h00;
    wire timed_disable_block = timed_disable_cnt != 14'h0000 && int_lvl <= `PRIC_TIMED_DISABLE_MAX;
    wire int_ok  = found && int_lvl > cpu_level && !nest_block && !timed_disable_block;
    wire trap_ok = tfound && trap_lvl > cpu_level;
    wire next_req = (trap_ok || int_ok) && !take;
    wire pric_pkg::pric_vec_t next_vec = trap_ok ? `PRIC_TRAP_VEC + {5'h00, tidx}
                                                 : `PRIC_INT_VEC + {1'b0, win_idx};
    wire pric_pkg::pric_lvl_t next_lvl = trap_ok ? trap_lvl : int_lvl;
    wire [23:0] next_vaddr = `PRIC_TBL_LO + {16'h0000, next_vec, 1'b0} +
                             (alt_table ? `PRIC_ALT_OFS : 24'h000000);

    pric_pkg::pric_lvl_t stk_rd;

    pric_lvl_stack u_stack (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (push),
        .wr_addr (depth[3:0]),
        .wr_data (cpu_level),
        .rd_addr (4'(next_depth - 5'h01)),
        .rd_data (stk_rd)
    );

    // Register read mux.
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_err  = 1'b1;
        for (int k = 0; k < `PRIC_NFLAG_REG; k++)
        begin
            if (hit(paddr, `PRIC_OFF_FLAGS0, k))
            begin
                rd_word = {16'h0000, pending[k*16 +: 16]};
                rd_err  = 1'b0;
            end
            if (hit(paddr, `PRIC_OFF_EN0, k))
            begin
                rd_word = {16'h0000, enables[k*16 +: 16]};
                rd_err  = 1'b0;
            end
        end
        for (int k = 0; k < `PRIC_NPRIO_REG; k++)
        begin
            if (hit(paddr, `PRIC_OFF_PRIO0, k))
            begin
                rd_err = 1'b0;
                for (int j = 0; j < 4; j++)
                begin
                    if (k * 4 + j < `PRIC_NLVL_SRC)
                    begin
                        rd_word[j*4 +: 4] = {1'b0, lvl[k*4 + j]};
                    end
                end
            end
        end
        if (paddr == `PRIC_OFF_GC1)
        begin
            rd_word = {16'h0000, nesting_disable, 11'h000, trap_flags};
            rd_err  = 1'b0;
        end
        if (paddr == `PRIC_OFF_GC2)
        begin
            rd_word = {16'h0000, alt_table, timed_disable_cnt != 14'h0000, 11'h000, ext_fall};
            rd_err  = 1'b0;
        end
        if (paddr == `PRIC_OFF_VLATCH)
        begin
            rd_word = {16'h0000, 4'h0, latched_request_level, 1'b0, latched_vector_number};
            rd_err  = 1'b0;
        end
        if (paddr == `PRIC_OFF_CPULVL)
        begin
            rd_word = {28'h0000000, cpu_level};
            rd_err  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup && rd_err;
            prdata  <= apb_setup ? rd_word : prdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pending    <= 48'h000000000000;
            enables    <= 48'h000000000000;
            trap_flags <= 4'h0;
            nesting_disable     <= 1'b0;
            alt_table  <= 1'b0;
            ext_fall   <= 3'h0;
        end
        else
        begin
            pending    <= next_pending;
            enables    <= next_enables;
            trap_flags <= next_traps;
            nesting_disable     <= gc1_wr ? pwdata[`PRIC_GC1_NESTING_DISABLE] : nesting_disable;
            alt_table  <= gc2_wr ? pwdata[`PRIC_GC2_ALT] : alt_table;
            ext_fall   <= gc2_wr ? pwdata[2:0] : ext_fall;
        end
    end

    // Sources above the last implemented nibble keep level zero and never win.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `PRIC_NSRC; i++)
            begin
                lvl[i] <= 3'h0;
            end
        end
        else
        begin
            for (int i = 0; i < `PRIC_NLVL_SRC; i++)
            begin
                if (apb_wr && hit(paddr, `PRIC_OFF_PRIO0, i / 4))
                begin
                    lvl[i] <= pwdata[(i % 4) * 4 +: 3];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1       <= 3'h0;
            s2       <= 3'h0;
            s3       <= 3'h0;
            ext_filt <= 3'h0;
            timed_disable_cnt <= 14'h0000;
        end
        else
        begin
            s1       <= ext_req_pin;
            s2       <= s1;
            s3       <= s2;
            ext_filt <= ext_new;
            timed_disable_cnt <= timed_disable_start ? timed_disable_count :
                        (instr_done && timed_disable_cnt != 14'h0000) ? timed_disable_cnt - 14'h0001 : timed_disable_cnt;
        end
    end

    // Only one saved level per nesting step is kept; a seventeenth nested entry
    // is not saved, so its return restores the level saved by the sixteenth entry.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_req               <= 1'b0;
            irq_vector            <= 7'h00;
            irq_level             <= 4'h0;
            irq_vec_addr          <= 24'h000000;
            latched_vector_number <= 7'h00;
            latched_request_level <= 4'h0;
            cpu_level             <= 4'h0;
            depth                 <= 5'h00;
            pc_vector             <= 24'h000000;
            pc_load               <= 1'b0;
        end
        else
        begin
            irq_req      <= next_req;
            irq_vector   <= next_vec;
            irq_level    <= next_lvl;
            irq_vec_addr <= next_vaddr;
            depth        <= next_depth;
            pc_load      <= vec_fetch_valid;
            pc_vector    <= vec_fetch_valid ? pdb_data : pc_vector;
            if (take)
            begin
                latched_vector_number <= irq_vector;
                latched_request_level <= irq_level;
                cpu_level             <= irq_level;
            end
            else if (pop)
            begin
                cpu_level <= stk_rd;
            end
            else if (cpu_wr_req && !nesting_disable)
            begin
                cpu_level <= pwdata[3:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take;
        irq_req && irq_ack;
    endsequence

    sequence s_timed_disable_req;
        timed_disable_cnt != 14'h0000 ##1 irq_req;
    endsequence

    property p_ack_latch;
        s_take |=> latched_vector_number == $past(irq_vector) &&
                   latched_request_level == $past(irq_level) &&
                   cpu_level == $past(irq_level) && !irq_req;
    endproperty

    a_flag_sticky: assert property (!flags_wr |=> ($past(pending) & ~pending) == 48'h0)
        else $error("pending flag cleared without a software write");
    a_flag_set: assert property (1'b1 |=> (pending & $past(irq_src)) == $past(irq_src))
        else $error("source event did not set its pending flag");
    a_level_gate: assert property (irq_req && irq_level < `PRIC_TRAP_LVL |->
        irq_level > $past(cpu_level) && irq_level != 4'h0)
        else $error("request presented at or below the cpu level");
    a_nest_block: assert property ($past(nest_block) && irq_req |-> irq_level >= `PRIC_TRAP_LVL)
        else $error("interrupt presented while nesting is disabled");
    a_lvl_readonly: assert property (nesting_disable && cpu_wr_req && !take && !pop |=>
        $stable(cpu_level))
        else $error("cpu level changed by write under nesting disable");
    a_timed_disable_mask: assert property (s_timed_disable_req |-> irq_level > `PRIC_TIMED_DISABLE_MAX)
        else $error("low level request during timed disable");
    a_ack_latch: assert property (p_ack_latch)
        else $error("vector latch or cpu level wrong after acknowledge");
    a_addr_trap: assert property (fetch_valid && in_vec_space |=> trap_flags[`PRIC_ADDR_ERR])
        else $error("vector space fetch did not raise address error");
    a_trap_level: assert property (irq_req && irq_level >= `PRIC_TRAP_LVL |->
        irq_vector < `PRIC_INT_VEC)
        else $error("trap level paired with an interrupt vector");
endmodule

// [bench/pric_core_model.sv]
module pric_core_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       irq_req,
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_dly,
    output logic            irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    // A core busy with a long instruction takes the request late, so the delay is settable.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else
        begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            if (irq_req && ack_en && !irq_ack && wait_cnt == ack_dly)
                irq_ack <= 1'b1;
            else if (irq_req && ack_en && !irq_ack)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// [bench/priority_interrupt_controller_test.sv]
module priority_interrupt_controller_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [5:0] a;
        logic [2:0] la;
        logic [5:0] b;
        logic [2:0] lb;
        logic [3:0] cpu;
        logic [5:0] win;
        logic       req;
    } pric_row_t;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, errv;
    logic        fetch_valid, timed_disable_start, instr_done, irq_ack, irq_ret, vec_fetch_valid;
    logic        irq_req, pc_load, ack_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] irq_src, en;
    logic [191:0] pri;
    logic [2:0]  ext_req_pin;
    logic [3:0]  trap_evt, ack_dly, wl;
    logic [13:0] timed_disable_count;
    logic [23:0] fetch_addr, pdb_data;
    pric_pkg::pric_vec_t  irq_vector;
    pric_pkg::pric_lvl_t  irq_level, cpu_level;
    pric_pkg::pric_addr_t irq_vec_addr, pc_vector;
    int          err_total, cmp_count;
    pric_row_t   rows [8];
    pric_row_t   r;

    pric_top u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(irq_src), .ext_req_pin(ext_req_pin), .trap_evt(trap_evt),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .timed_disable_start(timed_disable_start),
        .timed_disable_count(timed_disable_count), .instr_done(instr_done), .irq_ack(irq_ack), .irq_ret(irq_ret),
        .vec_fetch_valid(vec_fetch_valid), .pdb_data(pdb_data), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_level(irq_level), .irq_vec_addr(irq_vec_addr),
        .pc_vector(pc_vector), .pc_load(pc_load), .cpu_level(cpu_level));

    pric_core_model u_core (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .ack_en(ack_en),
        .ack_dly(ack_dly), .irq_ack(irq_ack));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task pulse(input logic [47:0] m);
        @(posedge clk);
        irq_src <= m;
        @(posedge clk);
        irq_src <= 48'h0;
    endtask

    task ret();
        @(posedge clk);
        irq_ret <= 1'b1;
        @(posedge clk);
        irq_ret <= 1'b0;
    endtask

    task clr_flags();
        for (int k = 0; k < 3; k++)
            apb(1'b1, 8'h00 + 8'(4 * k), 32'h0);
    endtask

    // Stale flags are cleared before any source is enabled.
    task load_cfg();
        clr_flags();
        for (int k = 0; k < 12; k++)
            apb(1'b1, 8'h18 + 8'(4 * k), {16'h0, pri[16 * k +: 16]});
        for (int k = 0; k < 3; k++)
            apb(1'b1, 8'h0C + 8'(4 * k), {16'h0, en[16 * k +: 16]});
    endtask

    task take(input logic [3:0] lvl);
        int n;
        n = 0;
        @(posedge clk);
        ack_en <= 1'b1;
        while (cpu_level !== lvl && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        ack_en <= 1'b0;
        chk(cpu_level, lvl);
    endtask

    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #800000;
        err_total++;
        print_verdict();
    end

    initial
    begin
        {psel, penable, pwrite, fetch_valid, timed_disable_start, instr_done} = 6'h0;
        {irq_ret, vec_fetch_valid, ack_en, paddr, pwdata, irq_src} = '0;
        {ext_req_pin, trap_evt, ack_dly, timed_disable_count, fetch_addr, pdb_data} = '0;
        err_total = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        rows = '{'{6'h03, 3'h5, 6'h28, 3'h0, 4'h0, 6'h03, 1'b1},
                 '{6'h03, 3'h0, 6'h28, 3'h0, 4'h0, 6'h00, 1'b0},
                 '{6'h03, 3'h5, 6'h28, 3'h0, 4'h5, 6'h00, 1'b0},
                 '{6'h03, 3'h5, 6'h28, 3'h0, 4'h4, 6'h03, 1'b1},
                 '{6'h04, 3'h3, 6'h05, 3'h3, 4'h0, 6'h04, 1'b1},
                 '{6'h04, 3'h3, 6'h05, 3'h4, 4'h0, 6'h05, 1'b1},
                 '{6'h14, 3'h7, 6'h2D, 3'h7, 4'h6, 6'h14, 1'b1},
                 '{6'h2C, 3'h1, 6'h2D, 3'h1, 4'h0, 6'h2C, 1'b1}};
        tick(5);
        sys_rst <= 1'b0;
        rdchk(8'h54, 32'h0);
        rdchk(8'h00, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            pri = '0;
            en = '0;
            pri[4 * r.a +: 4] = {1'b0, r.la};
            pri[4 * r.b +: 4] = {1'b0, r.lb};
            en[r.a] = 1'b1;
            en[r.b] = 1'b1;
            wl = {1'b0, (r.win == r.a) ? r.la : r.lb};
            ack_dly <= i[0] ? 4'h5 : 4'h0;
            load_cfg();
            apb(1'b1, 8'h54, {28'h0, r.cpu});
            pulse((48'h1 << r.a) | (48'h1 << r.b));
            tick(3);
            chk(irq_req, r.req);
            if (r.req)
            begin
                chk(irq_vector, {1'b0, r.win} + 7'h08);
                chk(irq_level, wl);
                chk(irq_vec_addr, 24'h4 + 24'(2 * (8 + r.win)));
                take(wl);
                clr_flags();
                ret();
            end
        end
        pri = '0;
        en = '0;
        pri[4 * 7 +: 4] = 4'h2;
        load_cfg();
        apb(1'b1, 8'h54, 32'h0);
        pulse(48'h80);
        tick(20);
        rdchk(8'h00, 32'h80);
        chk(irq_req, 1'b0);
        apb(1'b1, 8'h0C, 32'h80);
        tick(3);
        chk(irq_vector, 7'h0F);
        take(4'h2);
        rdchk(8'h50, 32'h020F);
        apb(1'b1, 8'h48, 32'h8000);
        apb(1'b1, 8'h54, 32'h0);
        rdchk(8'h54, 32'h2);
        apb(1'b1, 8'h18, 32'h5000);
        apb(1'b1, 8'h0C, 32'h88);
        pulse(48'h8);
        tick(4);
        chk(irq_req, 1'b0);
        apb(1'b1, 8'h48, 32'h0);
        tick(3);
        chk(irq_vector, 7'h0B);
        take(4'h5);
        clr_flags();
        ret();
        ret();
        tick(2);
        chk(cpu_level, 4'h0);
        apb(1'b1, 8'h18, 32'h6000);
        @(posedge clk);
        timed_disable_start <= 1'b1;
        timed_disable_count <= 14'h2;
        @(posedge clk);
        timed_disable_start <= 1'b0;
        rdchk(8'h4C, 32'h4000);
        pulse(48'h8);
        tick(3);
        chk(irq_req, 1'b0);
        repeat (2)
        begin
            @(posedge clk);
            instr_done <= 1'b1;
            @(posedge clk);
            instr_done <= 1'b0;
        end
        tick(3);
        chk(irq_level, 4'h6);
        rdchk(8'h4C, 32'h0);
        take(4'h6);
        clr_flags();
        ret();
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h18, 32'hFFFF);
        rdchk(8'h18, 32'h7777);
        apb(1'b1, 8'h44, 32'hFFFF);
        rdchk(8'h44, 32'h0077);
        rdchk(8'h60, 32'h0);
        chk(errv, 32'h1);
        @(posedge clk);
        ext_req_pin <= 3'h1;
        tick(8);
        rdchk(8'h00, 32'h1);
        clr_flags();
        apb(1'b1, 8'h4C, 32'h1);
        @(posedge clk);
        ext_req_pin <= 3'h0;
        tick(8);
        rdchk(8'h00, 32'h1);
        clr_flags();
        @(posedge clk);
        vec_fetch_valid <= 1'b1;
        pdb_data <= 24'h123456;
        @(posedge clk);
        vec_fetch_valid <= 1'b0;
        #1;
        chk(pc_load, 32'h1);
        chk(pc_vector, 24'h123456);
        @(posedge clk);
        fetch_valid <= 1'b1;
        fetch_addr <= 24'h000010;
        @(posedge clk);
        fetch_valid <= 1'b0;
        tick(3);
        rdchk(8'h48, 32'h0002);
        chk(irq_level, 4'h9);
        chk(irq_vector, 7'h02);
        apb(1'b1, 8'h4C, 32'h8000);
        tick(2);
        chk(irq_vec_addr, 24'h000088);
        print_verdict();
    end
endmodule
